// file: common/dcdcr_pkg.sv
/*
 * Constants for the dc-dc converter configuration and mode register bank:
 * register indexes, field positions, reset values and bus widths.
 * Assumes a single system clock and a 32-bit classic Wishbone register bus.
 */
package dcdcr_pkg;

	// Register indexes; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_MODE = 8'h94;
	localparam logic [7:0] IDX_CLKCFG = 8'h96;
	localparam logic [7:0] IDX_CTRL = 8'h97;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
	localparam int ADR_LSB = 2;
	localparam int IDX_W = 8;

	// Register pages kept for software reference; the bus decode is flat
	localparam logic [3:0] PAGE_CLKCFG = 4'h0;
	localparam logic [3:0] PAGE_MODE = 4'hF;

	// Clock configuration fields
	localparam int CFG_LOW_BIAS = 7;
	localparam int CFG_DIV_HI = 6;
	localparam int CFG_DIV_LO = 5;
	localparam int CFG_SAR_POL = 4;
	localparam int CFG_CONV_POL = 3;
	localparam int CFG_PEAK_THR = 2;
	localparam int CFG_SLEEP_TIE = 1;
	localparam int CFG_CLK_SRC = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// Mode fields
	localparam int MODE_BYP_FLAG = 3;
	localparam int MODE_POL_HI = 2;
	localparam int MODE_POL_LO = 1;
	localparam int MODE_PASSIVE = 0;
	localparam logic [2:0] MODE_WR_RESET = 3'h0;

	// Control register: only the synchronization enable lives here
	localparam int CTRL_SYNC = 3;
	localparam logic CTRL_SYNC_RESET = 1'b0;

	// Interrupt status and mask bits
	localparam int IRQ_BYP_ENTER = 0;
	localparam int IRQ_BYP_LEAVE = 1;
	localparam int IRQ_W = 2;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	typedef enum logic [1:0]
	{
		DCDCR_BYP_OFF = 2'b00,
		DCDCR_BYP_AUTO_RUN = 2'b01,
		DCDCR_BYP_AUTO_STOP = 2'b10,
		DCDCR_BYP_FORCED = 2'b11
	} dcdcr_bypass_e;

	localparam logic [2:0] DIV_CNT_RESET = 3'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : dcdcr_pkg

// file: hw/dcdcr_regs.sv
/*
 * Configuration and mode register bank of the dc-dc boost converter, with
 * converter clock divider, bypass indicator synchronizer and bypass interrupt.
 * Assumes classic Wishbone master on clk_i, analog stage on the outputs, and
 * an asynchronous bypass status from the power stage.
 */
// How it works
// - Config bit 7 turns on low power mode
// - Bits 6:5 divide system clock by 1,2,4,8
// - Divider ignored when local oscillator selected
// - Bit 0 picks local oscillator or system clock
// - Bit 3 inverts system clock before divider
// - Bit 4 zero inverts SAR clock under sync
// - Bit 2 selects peak current threshold
// - Sleep with converter on: bit1 zero ties battery
// - Config register at 0x96, all RW, reset zero
// - Mode register decoded at 0x94
// - Mode bits 7:4 read zero, writes ignored
// - Mode bit 3 read-only live bypass indicator
// - Bypass code 00 off, 11 forced, reset 00
// - Code 01 auto with oscillator, 10 auto stopped
// - Mode bit 0 enables passive diode mode
// - Sync enable gates SAR clock inversion
`timescale 1ns/1ps
module dcdcr_regs
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bypass_status_i,
	input wire logic converter_enabled_i,
	input wire logic sleep_mode_i,
	output logic low_bias_mode_on_o,
	output logic conv_clock_source_o,
	output logic [1:0] conv_clock_divider_o,
	output logic conv_clock_polarity_o,
	output logic conv_tick_o,
	output logic sar_clock_polarity_o,
	output logic sync_enable_o,
	output logic peak_current_threshold_o,
	output logic sleep_output_tie_o,
	output logic [1:0] bypass_policy_o,
	output logic bypass_auto_o,
	output logic bypass_forced_o,
	output logic conv_osc_run_o,
	output logic passive_rectifier_on_o,
	output logic irq_o
);

	logic [7:0] converter_clock_config;
	logic [2:0] mode_wr;
	logic sync_en;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic byp_meta;
	logic byp_sync;
	logic byp_prev;
	logic [2:0] div_cnt;

	// Bus decode
	wire [7:0] idx = wb_adr_i[dcdcr_pkg::ADR_LSB +: dcdcr_pkg::IDX_W];
	wire hit_upper = (wb_adr_i[11:10] == 2'h0);
	wire req = wb_cyc_i && wb_stb_i;
	wire take = req && wb_ack_o;
	wire wr_lane0 = take && wb_we_i && wb_sel_i[0];
	wire sel_cfg = hit_upper && (idx == dcdcr_pkg::IDX_CLKCFG);
	wire sel_mode = hit_upper && (idx == dcdcr_pkg::IDX_MODE);
	wire sel_ctrl = hit_upper && (idx == dcdcr_pkg::IDX_CTRL);
	wire sel_stat = hit_upper && (idx == dcdcr_pkg::IDX_IRQ_STATUS);
	wire sel_mask = hit_upper && (idx == dcdcr_pkg::IDX_IRQ_MASK);
	wire wr_cfg = wr_lane0 && sel_cfg;
	wire wr_mode = wr_lane0 && sel_mode;
	wire wr_ctrl = wr_lane0 && sel_ctrl;
	wire wr_mask = wr_lane0 && sel_mask;
	wire rd_stat = take && !wb_we_i && sel_stat;

	// Mode reads: upper nibble zero, bit 3 is the synchronized bypass flag
	wire [7:0] mode_rd = {4'h0, byp_sync, mode_wr};
	wire [7:0] ctrl_rd = {4'h0, sync_en, 3'h0};
	wire [7:0] rd_byte = sel_cfg ? converter_clock_config :
		sel_mode ? mode_rd :
		sel_ctrl ? ctrl_rd :
		sel_stat ? {6'h0, irq_status} :
		sel_mask ? {6'h0, irq_mask} : 8'h00;
	wire [31:0] next_dat = req && !wb_ack_o && !wb_we_i ? {24'h00_0000, rd_byte} : dcdcr_pkg::RDATA_RESET;

	// Register write paths
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			converter_clock_config <= dcdcr_pkg::CFG_RESET;
			mode_wr <= dcdcr_pkg::MODE_WR_RESET;
			sync_en <= dcdcr_pkg::CTRL_SYNC_RESET;
			irq_mask <= dcdcr_pkg::IRQ_RESET;
		end
		else
		begin
			if (wr_cfg)
				converter_clock_config <= wb_dat_i[7:0];
			if (wr_mode)
				mode_wr <= wb_dat_i[2:0];
			if (wr_ctrl)
				sync_en <= wb_dat_i[dcdcr_pkg::CTRL_SYNC];
			if (wr_mask)
				irq_mask <= wb_dat_i[1:0];
		end
	end

	// Ack is one cycle per request; the write lands on the ack edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= dcdcr_pkg::RDATA_RESET;
		end
		else
		begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= next_dat;
		end
	end

	// Bypass status comes from the analog stage; left unreset so the flag
	// shows the real converter state even straight after reset
	always_ff @(posedge clk_i)
	begin
		byp_meta <= bypass_status_i;
		byp_sync <= byp_meta;
		byp_prev <= byp_sync;
	end

	wire byp_enter = byp_sync && !byp_prev;
	wire byp_leave = !byp_sync && byp_prev;
	wire [1:0] irq_events = {byp_leave, byp_enter};
	// A new event in the clearing read cycle survives the clear
	wire [1:0] next_irq_status = (rd_stat ? 2'h0 : irq_status) | irq_events;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_status <= dcdcr_pkg::IRQ_RESET;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_o <= |(next_irq_status & irq_mask);
		end
	end

	// Converter clock divider on the system clock path
	wire src_sys = converter_clock_config[dcdcr_pkg::CFG_CLK_SRC];
	wire [1:0] div_sel = converter_clock_config[dcdcr_pkg::CFG_DIV_HI:dcdcr_pkg::CFG_DIV_LO];
	wire conv_inv = converter_clock_config[dcdcr_pkg::CFG_CONV_POL];
	wire [2:0] div_mask = 3'((4'h1 << div_sel) - 4'h1);
	wire [2:0] div_phase = conv_inv ? 3'(div_mask >> 1) + 3'(div_sel != 2'h0) : 3'h0;
	// Local oscillator source means the divider setting has no effect at all
	wire next_tick = src_sys && ((div_cnt & div_mask) == div_phase);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			div_cnt <= dcdcr_pkg::DIV_CNT_RESET;
		else
			div_cnt <= div_cnt + 3'h1;
	end

	// Outputs to the power stage and the sar converter
	wire [1:0] pol = mode_wr[dcdcr_pkg::MODE_POL_HI:dcdcr_pkg::MODE_POL_LO];
	wire next_sar_inv = sync_en && !converter_clock_config[dcdcr_pkg::CFG_SAR_POL];
	wire next_tie = converter_enabled_i && sleep_mode_i &&
		!converter_clock_config[dcdcr_pkg::CFG_SLEEP_TIE];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			low_bias_mode_on_o <= 1'b0;
			conv_clock_source_o <= 1'b0;
			conv_clock_divider_o <= 2'h0;
			conv_clock_polarity_o <= 1'b0;
			conv_tick_o <= 1'b0;
			sar_clock_polarity_o <= 1'b0;
			sync_enable_o <= 1'b0;
			peak_current_threshold_o <= 1'b0;
			sleep_output_tie_o <= 1'b0;
			bypass_policy_o <= 2'h0;
			bypass_auto_o <= 1'b0;
			bypass_forced_o <= 1'b0;
			conv_osc_run_o <= 1'b1;
			passive_rectifier_on_o <= 1'b0;
		end
		else
		begin
			low_bias_mode_on_o <= converter_clock_config[dcdcr_pkg::CFG_LOW_BIAS];
			conv_clock_source_o <= src_sys;
			conv_clock_divider_o <= src_sys ? div_sel : 2'h0;
			conv_clock_polarity_o <= src_sys && conv_inv;
			conv_tick_o <= next_tick;
			sar_clock_polarity_o <= next_sar_inv;
			sync_enable_o <= sync_en;
			peak_current_threshold_o <= converter_clock_config[dcdcr_pkg::CFG_PEAK_THR];
			sleep_output_tie_o <= next_tie;
			bypass_policy_o <= pol;
			bypass_auto_o <= (pol == dcdcr_pkg::DCDCR_BYP_AUTO_RUN) ||
				(pol == dcdcr_pkg::DCDCR_BYP_AUTO_STOP);
			bypass_forced_o <= (pol == dcdcr_pkg::DCDCR_BYP_FORCED);
			conv_osc_run_o <= (pol != dcdcr_pkg::DCDCR_BYP_AUTO_STOP);
			passive_rectifier_on_o <= mode_wr[dcdcr_pkg::MODE_PASSIVE];
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_LOW_BIAS: assert property (##1 low_bias_mode_on_o == $past(converter_clock_config[7]))
		else $error("low bias output does not follow config bit 7");
	AST_DIV_PERIOD: assert property ((conv_tick_o && $stable(converter_clock_config) &&
		div_sel == 2'h1 && src_sys) ##1 $stable(converter_clock_config) |=> conv_tick_o)
		else $error("divide by two tick period wrong");
	AST_DIV_FOUR: assert property ((conv_tick_o && div_sel == 2'h2 && $stable(converter_clock_config))
		##1 $stable(converter_clock_config) [*3] |=> conv_tick_o)
		else $error("divide by four tick period wrong");
	AST_LOCAL_OSC: assert property (!src_sys ##1 !src_sys |-> !conv_tick_o && conv_clock_divider_o == 2'h0)
		else $error("divider active on local oscillator");
	AST_SRC: assert property ($rose(src_sys) |=> conv_clock_source_o)
		else $error("clock source output did not follow select");
	AST_SAR_POL: assert property (!sync_en ##1 1'b1 |-> !sar_clock_polarity_o)
		else $error("sar inversion active without sync");
	AST_TIE: assert property (next_tie |=> sleep_output_tie_o)
		else $error("sleep supply tie not applied");
	AST_CFG_WRITE: assert property (wr_cfg |=> converter_clock_config == $past(wb_dat_i[7:0]))
		else $error("config write lost");
	AST_MODE_UPPER: assert property (wb_ack_o && $past(sel_mode && !wb_we_i) |-> wb_dat_o[7:4] == 4'h0)
		else $error("mode upper bits not zero");
	AST_BYP_FLAG: assert property (wb_ack_o && $past(sel_mode && !wb_we_i) |-> wb_dat_o[3] == $past(byp_sync))
		else $error("bypass flag read wrong");
	AST_FORCED: assert property (pol == 2'h3 |=> bypass_forced_o && !bypass_auto_o)
		else $error("forced bypass not applied");
	AST_OSC_STOP: assert property (pol == 2'h2 |=> bypass_auto_o && !conv_osc_run_o)
		else $error("auto bypass with stopped oscillator wrong");
	AST_PASSIVE: assert property (wr_mode |=> ##1 passive_rectifier_on_o == $past(wb_dat_i[0], 2))
		else $error("passive diode bit not applied");
	AST_SYNC_PIPE: assert property (##2 byp_sync == $past(bypass_status_i, 2))
		else $error("bypass synchronizer depth wrong");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");

	// Config and control outputs against their sources one cycle earlier
	AST_LOW_BIAS_OFF: assert property (!converter_clock_config[dcdcr_pkg::CFG_LOW_BIAS]
		|=> !low_bias_mode_on_o)
		else $error("low bias output set while config bit clear");
	AST_DIV_ONE: assert property ((src_sys && div_sel == 2'h0)
		##1 (src_sys && div_sel == 2'h0) |=> conv_tick_o)
		else $error("divide by one tick missing");
	AST_DIV_OUT: assert property (src_sys
		|=> conv_clock_divider_o == $past(div_sel))
		else $error("divider output does not follow field");
	AST_SRC_LOW: assert property (!src_sys
		|=> !conv_clock_source_o)
		else $error("clock source output high on local oscillator");
	AST_CLK_POL: assert property ((src_sys && conv_inv)
		|=> conv_clock_polarity_o)
		else $error("converter clock not inverted");
	AST_CLK_POL_OFF: assert property (!conv_inv
		|=> !conv_clock_polarity_o)
		else $error("converter clock inverted with bit clear");
	AST_SAR_INV: assert property ((sync_en && !converter_clock_config[dcdcr_pkg::CFG_SAR_POL])
		|=> sar_clock_polarity_o)
		else $error("sar clock not inverted under sync");
	AST_SAR_NORM: assert property (converter_clock_config[dcdcr_pkg::CFG_SAR_POL]
		|=> !sar_clock_polarity_o)
		else $error("sar clock inverted with bit set");
	AST_PEAK: assert property (##1
		peak_current_threshold_o == $past(converter_clock_config[dcdcr_pkg::CFG_PEAK_THR]))
		else $error("peak current threshold does not follow config");
	AST_FLOAT: assert property (converter_clock_config[dcdcr_pkg::CFG_SLEEP_TIE]
		|=> !sleep_output_tie_o)
		else $error("supply tied although floating selected");
	AST_TIE_AWAKE: assert property (!sleep_mode_i
		|=> !sleep_output_tie_o)
		else $error("supply tied outside sleep");
	AST_SYNC_OUT: assert property (##1
		sync_enable_o == $past(sync_en))
		else $error("sync enable output wrong");

	// Register storage and read data
	AST_CFG_HOLD: assert property (!wr_cfg
		|=> $stable(converter_clock_config))
		else $error("config changed without a write");
	AST_CFG_READ: assert property ((wb_ack_o && $past(sel_cfg && !wb_we_i))
		|-> wb_dat_o[7:0] == $past(converter_clock_config))
		else $error("config read data wrong");
	AST_MODE_DEC: assert property ((wr_lane0 && hit_upper && idx == dcdcr_pkg::IDX_MODE)
		|=> mode_wr == $past(wb_dat_i[2:0]))
		else $error("mode write at its index lost");
	AST_MODE_HOLD: assert property (!wr_mode
		|=> $stable(mode_wr))
		else $error("mode changed without a write");
	AST_MODE_READ: assert property ((wb_ack_o && $past(sel_mode && !wb_we_i))
		|-> wb_dat_o[0] == $past(mode_wr[dcdcr_pkg::MODE_PASSIVE]))
		else $error("passive diode bit read wrong");

	// Bypass policy and passive diode decode
	AST_BYP_OFF: assert property (pol == 2'h0
		|=> !bypass_auto_o && !bypass_forced_o)
		else $error("bypass active with policy off");
	AST_AUTO_RUN: assert property (pol == 2'h1
		|=> bypass_auto_o && conv_osc_run_o && !bypass_forced_o)
		else $error("auto bypass with running oscillator wrong");
	AST_OSC_RUN: assert property (pol != 2'h2
		|=> conv_osc_run_o)
		else $error("oscillator stopped outside stop policy");
	AST_PASSIVE_OFF: assert property (!mode_wr[dcdcr_pkg::MODE_PASSIVE]
		|=> !passive_rectifier_on_o)
		else $error("passive diode mode on with bit clear");

	// Interrupt status and bus handshake
	AST_SET_WINS: assert property ((rd_stat && byp_enter)
		|=> irq_status[dcdcr_pkg::IRQ_BYP_ENTER])
		else $error("event lost in clearing read");
	AST_STAT_CLEAR: assert property ((rd_stat && !byp_enter && !byp_leave)
		|=> irq_status == 2'h0)
		else $error("status not cleared by read");
	AST_IRQ_LEVEL: assert property ($stable(irq_mask)
		|-> irq_o == |(irq_status & irq_mask))
		else $error("interrupt level wrong");
	AST_ACK_RESP: assert property ((req && !wb_ack_o)
		|=> wb_ack_o)
		else $error("request not acknowledged");
	AST_DAT_IDLE: assert property (!wb_ack_o
		|-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack cycle");

	COV_CFG_WRITE: cover property (wr_cfg);
	COV_STATUS_CLEAR: cover property (rd_stat && |irq_status);
	COV_IRQ: cover property ($rose(irq_o));
	COV_DIV_EIGHT: cover property (src_sys && div_sel == 2'h3 && conv_tick_o);
	COV_FORCED_BYP: cover property (bypass_forced_o && byp_sync);

endmodule : dcdcr_regs

// file: sim/dcdcr_stage_model.sv
/*
 * Behavioural power stage: reports bypass state from the bypass policy.
 * Assumes the bench drives line_above_i (input above programmed output).
 */
`timescale 1ns/1ps
module dcdcr_stage_model
(
	input wire logic clk_i,
	input wire logic [1:0] bypass_policy_i,
	input wire logic line_above_i,
	output logic bypass_status_o
);
	wire auto_sw = (bypass_policy_i == 2'b01) || (bypass_policy_i == 2'b10);
	// Registered so the pin changes a cycle after the policy, like a slow analog stage
	always @(posedge clk_i)
	begin
		bypass_status_o <= (bypass_policy_i == 2'b11) || (auto_sw && line_above_i);
	end
endmodule : dcdcr_stage_model

// file: sim/dcdcr_regs_tb.sv
/*
 * Self-checking bench for the converter register bank over classic Wishbone.
 * Assumes one clock and a behavioural power stage model on the bypass pin.
 */
`timescale 1ns/1ps
module dcdcr_regs_tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, line_above = 0, conv_en = 0, sleep = 0, byp;
	logic [11:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, q, wb_dat_o;
	logic wb_ack_o, lb, src, pol, tick, sar, sync, thr, tie, aut, frc, osc, pas, irq;
	logic [1:0] dv, pl;
	int n_mismatch = 0, num_checks = 0, cycles = 0, t;
	always #2 clk_i = ~clk_i;
	dcdcr_regs dcdcr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.bypass_status_i(byp), .converter_enabled_i(conv_en), .sleep_mode_i(sleep), .low_bias_mode_on_o(lb),
		.conv_clock_source_o(src), .conv_clock_divider_o(dv), .conv_clock_polarity_o(pol), .conv_tick_o(tick),
		.sar_clock_polarity_o(sar), .sync_enable_o(sync), .peak_current_threshold_o(thr),
		.sleep_output_tie_o(tie), .bypass_policy_o(pl), .bypass_auto_o(aut), .bypass_forced_o(frc),
		.conv_osc_run_o(osc), .passive_rectifier_on_o(pas), .irq_o(irq));
	dcdcr_stage_model dcdcr_stage_model_inst (.clk_i(clk_i), .bypass_policy_i(pl), .line_above_i(line_above),
		.bypass_status_o(byp));
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk
	// One classic cycle; data is taken at the edge where ack is sampled high
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; sel <= 4'h1;
		adr <= {2'b00, idx, 2'b00};
		dat <= {24'h00_0000, d};
		n = 0;
		do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
		if (n == 20)
			chk("ack", 1, 0);
		q = wb_dat_o;
		cyc <= 0; stb <= 0; we <= 0;
	endtask : xfer
	task wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1, idx, d);
		repeat (2) @(posedge clk_i);
		#1;
	endtask : wr
	task rd(input string nm, input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
		xfer(0, idx, 8'h00);
		chk(nm, {24'h00_0000, e & m}, q & {24'h00_0000, m});
	endtask : rd
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		#1 chk("osc_reset", 1, osc);
		chk("irq_reset", 0, irq);
		rd("cfg_reset", dcdcr_pkg::IDX_CLKCFG, 8'h00, 8'hFF);
		rd("mode_reset", dcdcr_pkg::IDX_MODE, 8'h00, 8'hFF);
		rd("unmapped", 8'h10, 8'h00, 8'hFF);
		wr(dcdcr_pkg::IDX_CLKCFG, 8'hFF);
		rd("cfg_rw", dcdcr_pkg::IDX_CLKCFG, 8'hFF, 8'hFF);
		chk("cfg_outs", 6'h3F, {lb, src, dv, pol, thr});
		wr(dcdcr_pkg::IDX_CLKCFG, 8'h7E);
		t = 0;
		repeat (16) begin @(posedge clk_i); #1 t += tick; end
		chk("local_osc", 6'h00, {lb, src, dv, pol, t != 0});
		for (int d = 0; d < 4; d++)
		begin
			wr(dcdcr_pkg::IDX_CLKCFG, {1'b0, d[1:0], 5'h01});
			t = 0;
			repeat (32) begin @(posedge clk_i); #1 t += tick; end
			chk("ticks", 32 >> d, t);
		end
		wr(dcdcr_pkg::IDX_CTRL, 8'h08);
		chk("sar_inv", 2'b11, {sync, sar});
		wr(dcdcr_pkg::IDX_CLKCFG, 8'h10);
		chk("sar_norm", 0, sar);
		wr(dcdcr_pkg::IDX_CTRL, 8'h00);
		wr(dcdcr_pkg::IDX_CLKCFG, 8'h00);
		chk("sar_nosync", 0, sar);
		@(posedge clk_i);
		conv_en <= 1; sleep <= 1;
		repeat (3) @(posedge clk_i);
		#1 chk("tie_bat", 1, tie);
		wr(dcdcr_pkg::IDX_CLKCFG, 8'h02);
		chk("tie_float", 0, tie);
		for (int p = 0; p < 4; p++)
		begin
			wr(dcdcr_pkg::IDX_MODE, {5'h1F, p[1:0], 1'b1});
			chk("policy", {p[1:0], p == 1 || p == 2, p == 3, p != 2, 1'b1}, {pl, aut, frc, osc, pas});
			rd("mode_rb", dcdcr_pkg::IDX_MODE, {5'h00, p[1:0], 1'b1}, 8'hF7);
		end
		wr(dcdcr_pkg::IDX_MODE, 8'h00);
		repeat (8) @(posedge clk_i);
		rd("st_clr", dcdcr_pkg::IDX_IRQ_STATUS, 8'h03, 8'hFF);
		wr(dcdcr_pkg::IDX_IRQ_MASK, 8'h01);
		wr(dcdcr_pkg::IDX_MODE, 8'h06);
		repeat (8) @(posedge clk_i);
		#1 chk("irq_enter", 1, irq);
		rd("flag_on", dcdcr_pkg::IDX_MODE, 8'h0E, 8'hFF);
		rd("st_enter", dcdcr_pkg::IDX_IRQ_STATUS, 8'h01, 8'hFF);
		repeat (2) @(posedge clk_i);
		#1 chk("irq_clr", 0, irq);
		wr(dcdcr_pkg::IDX_MODE, 8'h02);
		repeat (8) @(posedge clk_i);
		#1 chk("irq_masked", 0, irq);
		rd("flag_off", dcdcr_pkg::IDX_MODE, 8'h02, 8'hFF);
		rd("st_leave", dcdcr_pkg::IDX_IRQ_STATUS, 8'h02, 8'hFF);
		@(posedge clk_i);
		line_above <= 1;
		repeat (8) @(posedge clk_i);
		rd("flag_auto", dcdcr_pkg::IDX_MODE, 8'h0A, 8'hFF);
		report_and_stop();
	end
endmodule : dcdcr_regs_tb
